// *** design/pet_regs.vh ***
`ifndef PET_REGS_VH
`define PET_REGS_VH
// Register byte offsets
`define PET_OFS_CTRL 12'h000
`define PET_OFS_STAT 12'h004
`define PET_OFS_CLR 12'h008
`define PET_OFS_CFG 12'h100
`define PET_OFS_WGT 12'h200
`define PET_OFS_TOT 12'h400
// Channel configuration fields
`define PET_CFG_QTY_LO 0
`define PET_CFG_QTY_HI 2
`define PET_CFG_PHS_LO 3
`define PET_CFG_PHS_HI 4
`define PET_CFG_DIR_LO 5
`define PET_CFG_DIR_HI 7
`define PET_CFG_RATE_LO 8
`define PET_CFG_RATE_HI 11
`define PET_CFG_EN_BIT 12
`define PET_CFG_ASSOC_LO 16
`define PET_CFG_SUB_LO 24
// Measured quantity codes
`define PET_QTY_NONE 3'h0
`define PET_QTY_WH 3'h1
`define PET_QTY_VARH 3'h2
// Direction codes; 4..7 pick quadrant 1..4
`define PET_DIR_DEL 3'h0
`define PET_DIR_REC 3'h1
`define PET_DIR_NET 3'h2
`define PET_DIR_ABS 3'h3
// Quadrant codes of the meter increment
`define PET_QUAD_1 2'h0
`define PET_QUAD_2 2'h1
`define PET_QUAD_4 2'h3
// Rate codes
`define PET_RATE_NONE 4'h0
`define PET_RATE_A 4'h1
`define PET_RATE_TOTAL 4'h9
// Reset values and bus answers
`define PET_CFG_RST 32'h0000_0000
`define PET_CTRL_RST 8'h00
`define PET_RESP_OKAY 2'h0
`define PET_RESP_SLVERR 2'h2
`endif

// *** design/pet_edge.v ***
`timescale 1ns/1ns
module pet_edge #(
  parameter N = 8
)(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Raw pulse inputs
  input wire [N-1:0] pulse_in,
  // Synchronised level and one-cycle transition pulse
  output wire [N-1:0] level,
  output wire [N-1:0] edge_pulse
);
  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1)
    begin : g_in
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg edge_r;
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          edge_r <= 1'b0;
        end
        else
        begin
          s1_r <= pulse_in[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // Make and break both count once, however long the level holds
          edge_r <= s2_r ^ s3_r; // RL10 RL17
        end
      end
      assign level[gi] = s3_r;
      assign edge_pulse[gi] = edge_r;
    end
  endgenerate
endmodule // pet_edge

// *** design/pet_meter_sel.v ***
`timescale 1ns/1ns
`include "pet_regs.vh"
module pet_meter_sel #(
  parameter WW = 24
)(
  // Channel settings
  input wire ch_en,
  input wire [2:0] ch_qty,
  input wire [1:0] ch_phase,
  input wire [2:0] ch_dir,
  input wire [3:0] ch_rate,
  // Meter increment
  input wire m_valid,
  input wire [2:0] m_qty,
  input wire [1:0] m_phase,
  input wire [1:0] m_quad,
  input wire [2:0] m_rate,
  input wire [WW-1:0] m_mag,
  // Signed contribution
  output reg signed [WW:0] contrib
);
  reg use_it;
  reg neg;
  reg del_q;
  reg rate_ok;
  always @*
  begin
    // Reactive delivered is quadrants 1-2, all others 1 and 4
    if (m_qty == `PET_QTY_VARH)
      del_q = (m_quad == `PET_QUAD_1) || (m_quad == `PET_QUAD_2);
    else
      del_q = (m_quad == `PET_QUAD_1) || (m_quad == `PET_QUAD_4);
    rate_ok = (ch_rate == `PET_RATE_NONE) || (ch_rate == `PET_RATE_TOTAL) ||
      (ch_rate == ({1'b0, m_rate} + `PET_RATE_A)); // RL5
    neg = 1'b0;
    case (ch_dir) // RL4
      `PET_DIR_DEL: use_it = del_q;
      `PET_DIR_REC: use_it = ~del_q;
      `PET_DIR_NET:
      begin
        use_it = 1'b1;
        neg = ~del_q;
      end
      `PET_DIR_ABS: use_it = 1'b1;
      default: use_it = (ch_qty == `PET_QTY_VARH) && (m_quad == ch_dir[1:0]);
    endcase
    contrib = {(WW+1){1'b0}};
    // None as quantity leaves only pulse energy
    if (m_valid && ch_en && rate_ok && use_it && (ch_qty != `PET_QTY_NONE) && // RL9 RL2
      (ch_qty == m_qty) && (ch_phase == m_phase)) // RL3
      contrib = neg ? -$signed({1'b0, m_mag}) : $signed({1'b0, m_mag});
  end
endmodule // pet_meter_sel

// *** design/pet_totalizer.v ***
`timescale 1ns/1ns
`include "pet_regs.vh"
// Operation
// RL1: Sixteen independent channels, each keeping its own running total.
// RL2: Quantity per channel: watt, var, VA, Q, amp, V2, A2 hours or none.
// RL3: Phase per channel: A, B, C or polyphase.
// RL4: Direction: delivered, received, net, absolute, or one reactive quadrant.
// RL5: Rate qualifier none, A to H, or total gates the meter contribution.
// RL6: Up to eight digital inputs per channel, each enabled as pulse counter.
// RL7: Separate pulse weight for every input and channel pairing.
// RL8: Add or subtract selection per associated input, applied to its contribution.
// RL9: Enable includes the meter registration; otherwise only pulse energy accumulates.
// RL10: Both make and break transitions count as one pulse.
// RL11: Each transition reaches every channel, which adds its own weight.
// RL12: Input registration is interval pulse count times pulse weight.
// RL13: Total is signed sum of input registrations plus enabled meter registration.
// RL14: Weights are signed fixed point, so a pulse can subtract energy.
// RL15: Profile consumers get the raw total; their direction and phase are bypassed.
// RL16: Log consumers get the raw total; only their units stay theirs.
// RL17: Inputs synchronised and edge detected from registered samples, one count each.
module pet_totalizer #(
  parameter NCH = 16,
  parameter NIN = 8,
  parameter TW = 32,
  parameter WW = 24,
  parameter AW = 12
)(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // External pulse inputs
  input wire [NIN-1:0] pulse_in,
  // Meter registration increments
  input wire meter_inc_valid,
  input wire [2:0] meter_qty,
  input wire [1:0] meter_phase,
  input wire [1:0] meter_quad,
  input wire [2:0] meter_rate,
  input wire [WW-1:0] meter_inc,
  // Totals to display, profile and log consumers
  output wire [NCH*TW-1:0] tot_value,
  output wire [NCH-1:0] tot_upd
);
  localparam CHB = $clog2(NCH);
  localparam INB = $clog2(NIN);
  localparam SB = CHB + INB;
  localparam CW = SB + 1;

  reg [NIN-1:0] pcnt_en_r;
  reg [31:0] cfg_r [0:NCH-1];
  reg [WW-1:0] wgt_r [0:NCH*NIN-1];
  reg [SB-1:0] step_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [1:0] rresp_r;
  reg [31:0] rdata_r;
  reg [31:0] rd_nxt;
  reg rd_hit;
  wire [NIN-1:0] lvl;
  wire [NIN-1:0] edg;
  wire [NIN*CW-1:0] snap_flat;
  integer k;
  integer kw;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (s[b])
          merge[b*8 +: 8] = d[b*8 +: 8];
    end
  endfunction

  pet_edge #(
    .N(NIN)
  ) u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pulse_in(pulse_in),
    .level(lvl),
    .edge_pulse(edg)
  );

  // Write address and data are taken together, one write in flight
  wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  wire [AW-1:0] wa = {s_axi_awaddr[AW-1:2], 2'b00};
  wire wa_ctrl = wa == `PET_OFS_CTRL;
  wire wa_clr = wa == `PET_OFS_CLR;
  wire wa_cfg = (wa >> (CHB + 2)) == (`PET_OFS_CFG >> (CHB + 2));
  wire wa_wgt = (wa >> (SB + 2)) == (`PET_OFS_WGT >> (SB + 2));
  wire [CHB-1:0] wa_ch = wa[CHB+1:2];
  wire [SB-1:0] wa_wi = wa[SB+1:2];
  wire wa_hit = wa_ctrl | wa_clr | wa_cfg | wa_wgt;
  wire [31:0] clr_word = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
  wire [NCH-1:0] clr_bits = (wr_fire && wa_clr) ? clr_word[NCH-1:0] : {NCH{1'b0}};
  // Byte lanes merged over the old contents, then cut back to the register width
  wire [31:0] ctrl_m = merge({{(32-NIN){1'b0}}, pcnt_en_r}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] wgt_m = merge({{(32-WW){1'b0}}, wgt_r[wa_wi]}, s_axi_wdata, s_axi_wstrb);

  // Unmapped addresses answer SLVERR and leave every register untouched
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `PET_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wa_hit ? `PET_RESP_OKAY : `PET_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pcnt_en_r <= `PET_CTRL_RST;
      for (k = 0; k < NCH; k = k + 1)
        cfg_r[k] <= `PET_CFG_RST;
    end
    else if (wr_fire)
    begin
      if (wa_ctrl)
        pcnt_en_r <= ctrl_m[NIN-1:0]; // RL6
      if (wa_cfg)
        cfg_r[wa_ch] <= merge(cfg_r[wa_ch], s_axi_wdata, s_axi_wstrb);
    end
  end

  // Weight store, one word per channel and input pair
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (kw = 0; kw < NCH * NIN; kw = kw + 1)
        wgt_r[kw] <= {WW{1'b0}};
    end
    else if (wr_fire && wa_wgt)
      wgt_r[wa_wi] <= wgt_m[WW-1:0]; // RL7
  end

  // Read side: one read in flight, answer one cycle after the address
  wire [AW-1:0] ra = {s_axi_araddr[AW-1:2], 2'b00};
  wire [CHB-1:0] ra_ch = ra[CHB+1:2];
  wire [SB-1:0] ra_wi = ra[SB+1:2];
  wire ra_ctrl = ra == `PET_OFS_CTRL;
  wire ra_stat = ra == `PET_OFS_STAT;
  wire ra_clr = ra == `PET_OFS_CLR;
  wire ra_cfg = (ra >> (CHB + 2)) == (`PET_OFS_CFG >> (CHB + 2));
  wire ra_wgt = (ra >> (SB + 2)) == (`PET_OFS_WGT >> (SB + 2));
  wire ra_tot = (ra >> (CHB + 2)) == (`PET_OFS_TOT >> (CHB + 2));
  wire rd_fire = s_axi_arvalid & ~rvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always @*
  begin
    rd_nxt = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ra_ctrl)
      rd_nxt[NIN-1:0] = pcnt_en_r;
    else if (ra_stat)
      rd_nxt[NIN-1:0] = lvl;
    else if (ra_clr)
      rd_nxt = 32'h0000_0000;
    else if (ra_cfg)
      rd_nxt = cfg_r[ra_ch];
    else if (ra_wgt)
      rd_nxt[WW-1:0] = wgt_r[ra_wi];
    else if (ra_tot)
      rd_nxt[TW-1:0] = tot_value[ra_ch*TW +: TW];
    else
      rd_hit = 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      rvalid_r <= 1'b0;
    else if (rd_fire)
      rvalid_r <= 1'b1;
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // Data and response move only on an accepted address, so they stand until rready
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rresp_r <= `PET_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (rd_fire)
    begin
      rresp_r <= rd_hit ? `PET_RESP_OKAY : `PET_RESP_SLVERR;
      rdata_r <= rd_nxt;
    end
  end

  // Sweep walks every channel and input pair, one per cycle
  wire sweep_end = &step_r;
  always @(posedge aclk)
  begin
    if (!aresetn)
      step_r <= {SB{1'b0}};
    else
      step_r <= step_r + {{(SB-1){1'b0}}, 1'b1};
  end

  // Pulse counts per input; the sweep length bounds them, so no saturation needed
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_cnt
      reg [CW-1:0] cnt_r;
      reg [CW-1:0] snap_r;
      wire hit = edg[gi] & pcnt_en_r[gi]; // RL6
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cnt_r <= {CW{1'b0}};
          snap_r <= {CW{1'b0}};
        end
        else if (sweep_end)
        begin
          // A pulse landing on the snapshot edge opens the next interval
          snap_r <= cnt_r; // RL12
          cnt_r <= {{(CW-1){1'b0}}, hit};
        end
        else
          cnt_r <= cnt_r + {{(CW-1){1'b0}}, hit};
      end
      assign snap_flat[gi*CW +: CW] = snap_r;
    end
  endgenerate

  // One shared multiplier serves the pair under the sweep
  wire [CHB-1:0] s_ch = step_r[SB-1:INB];
  wire [INB-1:0] s_in = step_r[INB-1:0];
  wire [31:0] s_cfg = cfg_r[s_ch];
  wire s_assoc = s_cfg[`PET_CFG_ASSOC_LO + s_in] & pcnt_en_r[s_in]; // RL6
  wire s_sub = s_cfg[`PET_CFG_SUB_LO + s_in];
  wire [CW-1:0] s_cnt = snap_flat[s_in*CW +: CW];
  wire signed [WW-1:0] s_wgt = wgt_r[step_r]; // RL7 RL14
  wire signed [CW+WW:0] prod = $signed({1'b0, s_cnt}) * s_wgt; // RL12 RL11
  wire signed [TW-1:0] prod_t = prod[TW-1:0];
  wire signed [TW-1:0] prod_n = -prod_t;
  wire signed [TW-1:0] pterm = !s_assoc ? {TW{1'b0}} : (s_sub ? prod_n : prod_t); // RL8

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc = gc + 1)
    begin : g_ch
      wire [31:0] c = cfg_r[gc];
      wire signed [WW:0] mc;
      wire signed [TW-1:0] mc_x = {{(TW-WW-1){mc[WW]}}, mc};
      wire here = s_ch == gc;
      wire last = here && (s_in == NIN - 1);
      reg signed [TW-1:0] acc_r;
      reg signed [TW-1:0] mpend_r;
      reg upd_r;
      wire signed [TW-1:0] fold = last ? mpend_r : {TW{1'b0}};
      pet_meter_sel #(
        .WW(WW)
      ) u_msel (
        .ch_en(c[`PET_CFG_EN_BIT]),
        .ch_qty(c[`PET_CFG_QTY_HI:`PET_CFG_QTY_LO]),
        .ch_phase(c[`PET_CFG_PHS_HI:`PET_CFG_PHS_LO]),
        .ch_dir(c[`PET_CFG_DIR_HI:`PET_CFG_DIR_LO]),
        .ch_rate(c[`PET_CFG_RATE_HI:`PET_CFG_RATE_LO]),
        .m_valid(meter_inc_valid),
        .m_qty(meter_qty),
        .m_phase(meter_phase),
        .m_quad(meter_quad),
        .m_rate(meter_rate),
        .m_mag(meter_inc),
        .contrib(mc)
      );
      always @(posedge aclk)
      begin
        if (!aresetn)
          upd_r <= 1'b0;
        else
          upd_r <= last;
      end

      // Clear wins over a same-cycle add; totals wrap at TW bits
      always @(posedge aclk)
      begin
        if (!aresetn)
          acc_r <= {TW{1'b0}};
        else if (clr_bits[gc])
          acc_r <= {TW{1'b0}};
        else if (here)
          acc_r <= acc_r + pterm + fold; // RL13 RL1
      end

      // Meter energy arriving as the pending sum is folded in is kept, not lost
      always @(posedge aclk)
      begin
        if (!aresetn)
          mpend_r <= {TW{1'b0}};
        else if (last)
          mpend_r <= mc_x; // RL9
        else
          mpend_r <= mpend_r + mc_x;
      end
      // Consumers take the bare total and apply their own units or scaling
      assign tot_value[gc*TW +: TW] = acc_r; // RL15 RL16
      assign tot_upd[gc] = upd_r;
    end
  endgenerate
endmodule // pet_totalizer

// *** testbench/pet_totalizer_props.sv ***
`timescale 1ns/1ns
module pet_tot_props #(
  parameter NCH = 16
)(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Totals
  input wire [NCH-1:0] tot_upd
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_ready_a: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready wrong");
  wready_same_a: assert property (s_axi_wready == s_axi_awready)
    else $error("wready differs from awready");
  bresp_time_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  bresp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  rd_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp))
    else $error("read data not held");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  upd_onehot_a: assert property ($onehot0(tot_upd))
    else $error("two channels updated at once");
  upd_gap_a: assert property (tot_upd != 0 |=> (tot_upd == 0) [*7])
    else $error("channel updates closer than eight cycles");
  wr_cov: cover property (s_axi_awvalid && s_axi_awready);
  rd_cov: cover property (s_axi_arvalid && s_axi_arready);
  upd_cov: cover property (tot_upd[NCH-1]);
endmodule // pet_tot_props

bind pet_totalizer pet_tot_props #(.NCH(NCH)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tot_upd(tot_upd));

// *** testbench/pet_pulse_src.sv ***
`timescale 1ns/1ns
module pet_pulse_src (
  // Clock
  input wire aclk,
  // Pulse lines
  output reg [7:0] pulse_in
);
  initial pulse_in = 8'h00;
  // Each level is held four cycles so the synchroniser never misses one
  task automatic toggle(input int i, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      pulse_in[i] <= ~pulse_in[i];
      repeat (3) @(posedge aclk);
    end
  endtask
endmodule // pet_pulse_src

// *** testbench/pet_totalizer_bench.sv ***
`timescale 1ns/1ns
`include "pet_regs.vh"
module pet_totalizer_bench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [11:0] awaddr = 12'h000;
  reg [11:0] araddr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg mv = 1'b0;
  reg [1:0] mquad = 2'h0;
  reg [2:0] mqty = 3'h1;
  reg [1:0] mph = 2'h3;
  reg [2:0] mrate = 3'h0;
  reg [23:0] minc = 24'h0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin;
  wire [511:0] tv;
  wire [15:0] tu;
  int n_mismatch = 0;
  int checks_done = 0;
  int cnt [0:7];
  logic [31:0] cfg [0:15];
  logic [23:0] w [0:15][0:7];
  logic [31:0] msum [0:15];
  logic [31:0] d;
  logic [1:0] r;
  always #2 aclk = ~aclk;
  pet_pulse_src src (.aclk(aclk), .pulse_in(pin));
  pet_totalizer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pulse_in(pin),
    .meter_inc_valid(mv), .meter_qty(mqty), .meter_phase(mph), .meter_quad(mquad),
    .meter_rate(mrate), .meter_inc(minc), .tot_value(tv), .tot_upd(tu));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= 12'(a);
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input int a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= 12'(a);
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Meter share of one increment for channel c, worked out from the channel's settings
  function automatic logic [31:0] m_part(input int c, input logic [2:0] qt, input logic [1:0] ph,
    input logic [1:0] q, input logic [2:0] rt, input logic [23:0] m);
    logic del;
    logic [3:0] rc;
    logic [31:0] v;
    del = (qt == `PET_QTY_VARH) ? (q <= 2'h1) : (q == 2'h0 || q == 2'h3);
    rc = cfg[c][11:8];
    v = {8'h00, m};
    if (!cfg[c][12] || cfg[c][2:0] == `PET_QTY_NONE || cfg[c][2:0] != qt || cfg[c][4:3] != ph)
      return 32'h0;
    if (rc != `PET_RATE_NONE && rc != `PET_RATE_TOTAL && rc != 4'(rt) + 4'h1)
      return 32'h0;
    case (cfg[c][7:5])
      `PET_DIR_DEL: return del ? v : 32'h0;
      `PET_DIR_REC: return del ? 32'h0 : v;
      `PET_DIR_NET: return del ? v : -v;
      `PET_DIR_ABS: return v;
      default: return (qt == `PET_QTY_VARH && {1'b1, q} == cfg[c][7:5]) ? v : 32'h0;
    endcase
  endfunction
  task automatic meter(input logic [2:0] qt, input logic [1:0] ph, input logic [1:0] q, input logic [2:0] rt,
    input logic [23:0] m);
    @(posedge aclk);
    mv <= 1'b1;
    mqty <= qt;
    mph <= ph;
    mquad <= q;
    mrate <= rt;
    minc <= m;
    for (int c = 0; c < 16; c++)
      msum[c] = msum[c] + m_part(c, qt, ph, q, rt, m);
    @(posedge aclk);
    mv <= 1'b0;
  endtask
  // Input 7 is left disabled in the control register, so it never counts
  function automatic logic [31:0] expect_tot(input int c);
    logic [31:0] s, p;
    s = msum[c];
    for (int i = 0; i < 7; i++)
    begin
      p = 32'(cnt[i]) * {{8{w[c][i][23]}}, w[c][i]};
      if (cfg[c][16+i])
        s = cfg[c][24+i] ? s - p : s + p;
    end
    return s;
  endfunction
  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #60000;
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    void'($urandom(32'h55a5));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      rd(k * 4 + ((k & 1) ? `PET_OFS_CFG : `PET_OFS_TOT), d, r);
      chk(d, 32'h0);
    end
    rd(12'h00C, d, r);
    chk({r, d[29:0]}, {`PET_RESP_SLVERR, 30'h0});
    wr(12'h00C, 32'hFFFFFFFF, r);
    chk(r, `PET_RESP_SLVERR);
    done_test("reset and unmapped");
    wr(`PET_OFS_CTRL, 32'h7F, r);
    for (int c = 0; c < 16; c++)
    begin
      cfg[c] = {16'($urandom), 3'h0, c[0], 4'($urandom % 10), 3'($urandom), 2'($urandom), 3'($urandom % 3)};
      msum[c] = 32'h0;
      for (int i = 0; i < 8; i++)
        w[c][i] = 24'($urandom);
    end
    cfg[1][31:16] = 16'h0001;
    cfg[2][15:0] = {3'h0, 1'b1, `PET_RATE_TOTAL, `PET_DIR_NET, 2'h3, `PET_QTY_WH};
    cfg[3][15:0] = {3'h0, 1'b1, `PET_RATE_NONE, 3'h6, 2'h1, `PET_QTY_VARH};
    w[1][0] = 24'hFFFFDA;
    for (int c = 0; c < 16; c++)
    begin
      wr(`PET_OFS_CFG + 4 * c, cfg[c], r);
      for (int i = 0; i < 8; i++)
        wr(`PET_OFS_WGT + 4 * (c * 8 + i), {8'h00, w[c][i]}, r);
    end
    for (int i = 0; i < 8; i++)
    begin
      cnt[i] = $urandom_range(4, 1);
      src.toggle(i, cnt[i]);
    end
    for (int j = 0; j < 16; j++)
      meter(3'(1 + (j & 1)), 2'(j >> 1), 2'($urandom), 3'($urandom), 24'($urandom & 32'hFFF));
    meter(`PET_QTY_WH, 2'h3, `PET_QUAD_2, 3'h0, 24'h00F000);
    meter(`PET_QTY_VARH, 2'h1, 2'h2, 3'h3, 24'h000ABC);
    repeat (600) @(posedge aclk);
    for (int c = 0; c < 16; c++)
    begin
      chk(tv[c*32+:32], expect_tot(c));
      rd(`PET_OFS_TOT + 4 * c, d, r);
      chk(d, expect_tot(c));
    end
    done_test("totals");
    rd(`PET_OFS_STAT, d, r);
    chk(d, {24'h0, pin});
    rd(`PET_OFS_WGT + 32, d, r);
    chk(d, 32'h00FFFFDA);
    rd(`PET_OFS_CTRL, d, r);
    chk(d, 32'h7F);
    wr(`PET_OFS_CLR, 32'h0000FFFF, r);
    repeat (3) @(posedge aclk);
    chk(tv[31:0] | tv[511:480], 32'h0);
    rd(`PET_OFS_CLR, d, r);
    chk(d, 32'h0);
    done_test("readback and clear");
    end_of_test;
  end
endmodule // pet_totalizer_bench
